/* core/pcds_pkg.sv */
package pcds_pkg;

  // ************************************************************
  // Register map: printed offsets are word indexes.
  // ************************************************************
  localparam logic [9:0] IDX_DEVICE_CONTROL = 10'h048;
  localparam logic [9:0] IDX_DEVICE_STATUS = 10'h04A;
  localparam logic [9:0] IDX_DEBUG_CONFIG = 10'h0F0;
  localparam logic [11:0] ADDR_DEVICE_CONTROL = {IDX_DEVICE_CONTROL, 2'b00};
  localparam logic [11:0] ADDR_DEVICE_STATUS = {IDX_DEVICE_STATUS, 2'b00};
  localparam logic [11:0] ADDR_DEBUG_CONFIG = {IDX_DEBUG_CONFIG, 2'b00};

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int CTL_CORR_POS = 0;
  localparam int CTL_NONFATAL_POS = 1;
  localparam int CTL_FATAL_POS = 2;
  localparam int CTL_UNSUPP_POS = 3;
  localparam int CTL_MPS_LSB = 5;
  localparam int CTL_EXT_TAG_POS = 8;
  localparam int DBG_SEQ_TAG_POS = 0;
  localparam int DBG_MPSS_LSB = 1;
  localparam int DBG_OVER_POS = 4;

  // ************************************************************
  // Reset values and constants.
  // ************************************************************
  localparam logic [3:0] RST_REPORT_ENABLES = 4'h0;
  localparam logic [2:0] RST_MAX_PAYLOAD_SETTING = 3'h0;
  localparam logic RST_EXTENDED_TAG_ENABLE = 1'b0;
  localparam logic RST_DEBUG_SEQUENTIAL_TAG = 1'b0;
  localparam logic [2:0] RST_MAX_PAYLOAD_SUPPORTED = 3'h4;
  localparam logic [3:0] RST_ERR_FLAGS = 4'h0;
  localparam logic [2:0] MPS_LARGEST_CODE = 3'h5;
  localparam logic [7:0] TAG_LIMIT_SHORT = 8'h1F;
  localparam logic [7:0] TAG_LIMIT_LONG = 8'hFF;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pcds_apb_req_type;

  // One bit per error class, in status bit order.
  typedef struct packed {
    logic unsupp;
    logic fatal;
    logic nonfatal;
    logic corr;
  } pcds_err_type;

  // Payload code to bytes; reserved codes act as 128 bytes.
  function automatic logic [12:0] pcds_payload_bytes(input logic [2:0] code);
    logic [12:0] bytes;
    bytes = 13'h0080;
    if (code <= MPS_LARGEST_CODE) begin
      bytes = 13'(13'h0080 << code);
    end
    return bytes;
  endfunction : pcds_payload_bytes

endpackage : pcds_pkg

/* core/pcds_err_flags.sv */
// Sticky write-one-to-clear error flags; a set beats a clear.
module pcds_err_flags (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_set,
  input wire logic [3:0] i_clr,
  output logic [3:0] o_flags
);
  import pcds_pkg::*;

  logic [3:0] flags_reg;
  logic [3:0] flags_next;

  // A zero in the clear mask leaves the flag alone.
  assign flags_next = i_set | (flags_reg & ~i_clr);

  // Flag storage.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flags_reg <= RST_ERR_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule : pcds_err_flags

/* core/pcds_top.sv */
module pcds_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire pcds_pkg::pcds_apb_req_type i_apb,
  input wire pcds_pkg::pcds_err_type i_err_event,
  input wire logic i_tag_take,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output pcds_pkg::pcds_err_type o_err_report,
  output pcds_pkg::pcds_err_type o_err_flags,
  output logic [12:0] o_max_payload_bytes,
  output logic [12:0] o_supported_payload_bytes,
  output logic o_payload_over,
  output logic [7:0] o_tag
);
  import pcds_pkg::*;

  // ************************************************************
  // Storage.
  // ************************************************************
  logic [3:0] report_en_reg;
  logic [2:0] mps_reg;
  logic ext_tag_reg;
  logic seq_tag_reg;
  logic [2:0] mpss_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic [3:0] report_reg;
  logic [12:0] payload_bytes_reg;
  logic [12:0] supported_bytes_reg;
  logic over_reg;
  logic [7:0] tag_reg;
  logic [7:0] tag_next;
  logic [3:0] flags;

  // ************************************************************
  // APB decode.
  // ************************************************************
  wire logic access = i_apb.psel && i_apb.penable;
  // The first access cycle is always a wait state, so pready is a flop.
  wire logic answer_now = access && !pready_reg;
  // Writes take effect only at the edge that samples pready high.
  wire logic commit = access && pready_reg;
  wire logic wr_commit = commit && i_apb.pwrite;
  wire logic hit_ctl = (i_apb.paddr == ADDR_DEVICE_CONTROL);
  wire logic hit_sts = (i_apb.paddr == ADDR_DEVICE_STATUS);
  wire logic hit_dbg = (i_apb.paddr == ADDR_DEBUG_CONFIG);
  wire logic mapped = hit_ctl || hit_sts || hit_dbg;
  wire logic wr_ctl = wr_commit && hit_ctl;
  wire logic wr_sts = wr_commit && hit_sts;
  wire logic wr_dbg = wr_commit && hit_dbg;

  // ************************************************************
  // Read values.
  // ************************************************************
  // Hardwired fields are simply absent from storage, so writes vanish.
  wire logic [15:0] ctl_view = {
    1'b0,   // reserved
    3'h0,
    1'b0,
    1'b0,
    1'b0,
    ext_tag_reg,
    mps_reg,
    1'b0,
    report_en_reg
  };
  wire logic [15:0] sts_view = {
    10'h000,
    1'b0,
    1'b0,
    flags
  };
  wire logic [31:0] dbg_view = {27'h000_0000, over_reg, mpss_reg, seq_tag_reg};
  wire logic [31:0] rd_value = hit_ctl ? {16'h0000, ctl_view}
                             : hit_sts ? {16'h0000, sts_view}
                             : hit_dbg ? dbg_view
                             : 32'h0000_0000;

  // Bus answer registers.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= answer_now;
      prdata_reg <= answer_now ? rd_value : 32'h0000_0000;
      pslverr_reg <= answer_now && !mapped;
    end
  end

  // ************************************************************
  // Control registers.
  // ************************************************************
  // Writable control and debug fields.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      report_en_reg <= RST_REPORT_ENABLES;
      mps_reg <= RST_MAX_PAYLOAD_SETTING;
      ext_tag_reg <= RST_EXTENDED_TAG_ENABLE;
      seq_tag_reg <= RST_DEBUG_SEQUENTIAL_TAG;
      mpss_reg <= RST_MAX_PAYLOAD_SUPPORTED;
    end else begin
      if (wr_ctl) begin
        report_en_reg <= i_apb.pwdata[CTL_UNSUPP_POS:CTL_CORR_POS];
        mps_reg <= i_apb.pwdata[CTL_MPS_LSB+:3];
        ext_tag_reg <= i_apb.pwdata[CTL_EXT_TAG_POS];
      end
      if (wr_dbg) begin
        seq_tag_reg <= i_apb.pwdata[DBG_SEQ_TAG_POS];
        mpss_reg <= i_apb.pwdata[DBG_MPSS_LSB+:3];
      end
    end
  end

  // ************************************************************
  // Error flags and reporting.
  // ************************************************************
  // Flags see every event; enables only gate the report pulses.
  pcds_err_flags u_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_set(i_err_event),
    .i_clr(wr_sts ? i_apb.pwdata[3:0] : 4'h0),
    .o_flags(flags)
  );

  // One report pulse per enabled event.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      report_reg <= 4'h0;
    end else begin
      report_reg <= i_err_event & report_en_reg;
    end
  end

  // ************************************************************
  // Payload size.
  // ************************************************************
  // Registered so the consumers see a clean level one cycle after a write.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      payload_bytes_reg <= pcds_payload_bytes(RST_MAX_PAYLOAD_SETTING);
      supported_bytes_reg <= pcds_payload_bytes(RST_MAX_PAYLOAD_SUPPORTED);
      over_reg <= 1'b0;
    end else begin
      payload_bytes_reg <= pcds_payload_bytes(mps_reg);
      supported_bytes_reg <= pcds_payload_bytes(mpss_reg);
      // A setting above support is undefined; it is only flagged.
      over_reg <= pcds_payload_bytes(mps_reg) > pcds_payload_bytes(mpss_reg);
    end
  end

  // ************************************************************
  // Debug sequential tags.
  // ************************************************************
  wire logic [7:0] tag_limit = ext_tag_reg ? TAG_LIMIT_LONG : TAG_LIMIT_SHORT;

  // Tags count only in debug mode and wrap at the chosen limit.
  always_comb begin
    tag_next = tag_reg;
    if (!seq_tag_reg) begin
      tag_next = 8'h00;
    end else if (i_tag_take) begin
      tag_next = (tag_reg >= tag_limit) ? 8'h00 : 8'(tag_reg + 8'h01);
    end
  end

  // Tag counter.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tag_reg <= 8'h00;
    end else begin
      tag_reg <= tag_next;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign o_pready = pready_reg;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;
  assign o_err_report = report_reg;
  assign o_err_flags = flags;
  assign o_max_payload_bytes = payload_bytes_reg;
  assign o_supported_payload_bytes = supported_bytes_reg;
  assign o_payload_over = over_reg;
  assign o_tag = tag_reg;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_corr_report_gate:
    assert property (o_err_report.corr == $past(i_err_event.corr
                     && report_en_reg[CTL_CORR_POS]))
    else $error("Correctable report not gated by its enable.");

  a_nonfatal_report_gate:
    assert property (i_err_event.nonfatal && !report_en_reg[1]
                     |=> !o_err_report.nonfatal)
    else $error("Non-fatal report leaked while disabled.");

  a_fatal_report_gate:
    assert property (i_err_event.fatal && report_en_reg[2]
                     |=> o_err_report.fatal)
    else $error("Fatal report missing while enabled.");

  a_unsupp_report_gate:
    assert property (i_err_event.unsupp && report_en_reg[3]
                     |=> o_err_report.unsupp)
    else $error("Unsupported request report missing.");

  a_ctl_hardwired_zero:
    assert property (answer_now && hit_ctl
                     |=> o_prdata[15:9] == 7'h00 && !o_prdata[4])
    else $error("Hardwired control bits read nonzero.");

  a_payload_decode:
    assert property (wr_ctl && i_apb.pwdata[7:5] == 3'h5
                     |=> ##1 o_max_payload_bytes == 13'h1000)
    else $error("Payload code 5 did not give 4096 bytes.");

  a_reserved_payload:
    assert property (mps_reg > MPS_LARGEST_CODE
                     |=> o_max_payload_bytes == 13'h0080)
    else $error("Reserved payload code not treated as 128 bytes.");

  a_tag_wrap_short:
    assert property (seq_tag_reg && !ext_tag_reg && i_tag_take
                     && tag_reg == 8'h1F |=> tag_reg == 8'h00)
    else $error("Short tag range did not wrap after 31.");

  a_flag_sticky_set:
    assert property (i_err_event.fatal |=> flags[2] ##1
                     (flags[2] || $past(wr_sts && i_apb.pwdata[2])))
    else $error("Fatal flag not held after event.");

  a_unsupp_sets_flag:
    assert property (i_err_event.unsupp |=> flags[3])
    else $error("Unsupported request did not set its flag.");

  a_w1c_zero_keeps:
    assert property (flags[0] && wr_sts && !i_apb.pwdata[0] |=> flags[0])
    else $error("Writing zero cleared a status flag.");

  a_w1c_clears:
    assert property (wr_sts && i_apb.pwdata[1] && !i_err_event.nonfatal
                     |=> !flags[1])
    else $error("Write one did not clear the non-fatal flag.");

  a_sts_hardwired:
    assert property (answer_now && hit_sts |=> o_prdata[31:4] == 28'h0)
    else $error("Status upper bits read nonzero.");

  a_enables_written:
    assert property (wr_ctl |=> report_en_reg ==
                     $past(i_apb.pwdata[CTL_UNSUPP_POS:CTL_CORR_POS]))
    else $error("Reporting enables did not take the written value.");

  a_mps_written:
    assert property (wr_ctl |=> mps_reg ==
                     $past(i_apb.pwdata[CTL_MPS_LSB+:3]))
    else $error("Payload setting did not take the written value.");

  a_ext_tag_written:
    assert property (wr_ctl |=> ext_tag_reg ==
                     $past(i_apb.pwdata[CTL_EXT_TAG_POS]))
    else $error("Extended tag enable did not take the written value.");

  a_tag_wrap_long:
    assert property (seq_tag_reg && ext_tag_reg && i_tag_take
                     && tag_reg == 8'hFF |=> tag_reg == 8'h00)
    else $error("Long tag range did not wrap after 255.");

  a_tag_idle_zero:
    assert property (!seq_tag_reg |=> tag_reg == 8'h00)
    else $error("Tag moved while sequential tag mode was off.");

  a_corr_sets_flag:
    assert property (i_err_event.corr |=> flags[0])
    else $error("Correctable error did not set its flag.");

  a_nonfatal_sets_flag:
    assert property (i_err_event.nonfatal |=> flags[1])
    else $error("Non-fatal error did not set its flag.");

  a_ctl_upper_zero:
    assert property (answer_now && hit_ctl
                     |=> o_prdata[31:15] == 17'h0_0000)
    else $error("Reserved control bits read nonzero.");

  a_sts_reserved_zero:
    assert property (answer_now && hit_sts
                     |=> o_prdata[15:6] == 10'h000)
    else $error("Reserved status bits read nonzero.");

  a_reserved_code_six:
    assert property (wr_ctl && i_apb.pwdata[CTL_MPS_LSB+:3] == 3'h6
                     |=> ##1 o_max_payload_bytes == 13'h0080)
    else $error("Payload code 6 did not give 128 bytes.");

  a_supported_default:
    assert property ($fell(i_rst) |-> mpss_reg == RST_MAX_PAYLOAD_SUPPORTED
                     && o_supported_payload_bytes == 13'h0800)
    else $error("Supported payload did not leave reset as 2048 bytes.");

  a_w1c_clears_fatal:
    assert property (wr_sts && i_apb.pwdata[2] && !i_err_event.fatal
                     |=> !flags[2])
    else $error("Write one did not clear the fatal flag.");

  a_unsupp_gate_off:
    assert property (i_err_event.unsupp && !report_en_reg[3]
                     |=> !o_err_report.unsupp)
    else $error("Unsupported request report leaked while disabled.");

  c_unsupp_reported: cover property (i_err_event.unsupp && report_en_reg[3]);
  c_flag_cleared: cover property (flags[0] ##1 !flags[0]);
  c_tag_long_wrap: cover property (ext_tag_reg && tag_reg == 8'hFF);
  c_unmapped_error: cover property (o_pslverr);
  c_payload_over: cover property (o_payload_over);

endmodule : pcds_top

/* tb/test_pcie_device_control_status.sv */
module test_pcie_device_control_status;
  timeunit 1ns;
  timeprecision 1ps;
  import pcds_pkg::*;

  // ************************************************************
  // Stimulus and observed signals.
  // ************************************************************
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  pcds_apb_req_type apb = '0;
  pcds_err_type err_ev = '0;
  logic tag_take = 1'b0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  pcds_err_type rep;
  pcds_err_type flags;
  logic [12:0] maxp;
  logic [12:0] supp;
  logic pover;
  logic [7:0] tag;
  int errors = 0;
  int n_compared = 0;

  // The clock toggles every half period of 10 ns.
  always #10 i_clk_sys = ~i_clk_sys;

  pcds_top pcds_top_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_apb(apb),
    .i_err_event(err_ev),
    .i_tag_take(tag_take),
    .o_pready(pready),
    .o_prdata(prdata),
    .o_pslverr(pslverr),
    .o_err_report(rep),
    .o_err_flags(flags),
    .o_max_payload_bytes(maxp),
    .o_supported_payload_bytes(supp),
    .o_payload_over(pover),
    .o_tag(tag)
  );

  // ************************************************************
  // Shared tasks.
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic exp_err,
                      output logic [31:0] rdat);
    int n;
    @(posedge i_clk_sys);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    apb.penable <= 1'b1;
    n = 0;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1);
    rdat = prdata;
    // The slave inserts exactly one wait state before pready.
    chk(32'(n), 32'h0000_0002);
    chk({31'h0, pslverr}, {31'h0, exp_err});
    apb <= '0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] r;
    xfer(1'b1, a, d, ee, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic ee);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, ee, r);
    chk(r, exp);
  endtask : rd

  // A one-cycle error pulse; report and flags are looked at a cycle later.
  task automatic pulse(input logic [3:0] e, input logic [3:0] rp,
                       input logic [3:0] fl);
    @(posedge i_clk_sys);
    err_ev <= e;
    @(posedge i_clk_sys);
    err_ev <= '0;
    #1;
    chk({28'h0, rep}, {28'h0, rp});
    chk({28'h0, flags}, {28'h0, fl});
  endtask : pulse

  task automatic takes(input int n, input logic [7:0] exp);
    repeat (n) begin
      @(posedge i_clk_sys);
      tag_take <= 1'b1;
    end
    @(posedge i_clk_sys);
    tag_take <= 1'b0;
    #1;
    chk({24'h0, tag}, {24'h0, exp});
  endtask : takes

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // A hang counts as a mismatch; the whole run needs far fewer cycles.
  initial begin
    #400000;
    errors++;
    conclude();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    logic [12:0] b;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk({19'h0, maxp}, 32'h0000_0080);
    chk({19'h0, supp}, 32'h0000_0800);
    rd(ADDR_DEVICE_CONTROL, 32'h0000_0000, 1'b0);
    rd(ADDR_DEVICE_STATUS, 32'h0000_0000, 1'b0);
    rd(ADDR_DEBUG_CONFIG, 32'h0000_0008, 1'b0);
    wr(ADDR_DEVICE_CONTROL, 32'hFFFF_FFFF, 1'b0);
    rd(ADDR_DEVICE_CONTROL, 32'h0000_01EF, 1'b0);
    wr(ADDR_DEVICE_STATUS, 32'hFFFF_FFFF, 1'b0);
    rd(ADDR_DEVICE_STATUS, 32'h0000_0000, 1'b0);
    wr(12'h124, 32'h0000_FFFF, 1'b1);
    rd(12'h124, 32'h0000_0000, 1'b1);
    // Every payload code, reserved ones included, against 2048 supported.
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_DEVICE_CONTROL, 32'(c) << 5, 1'b0);
      repeat (2) @(posedge i_clk_sys);
      #1;
      b = (c <= 5) ? 13'(13'h0080 << c) : 13'h0080;
      chk({19'h0, maxp}, {19'h0, b});
      chk({31'h0, pover}, {31'h0, b > 13'h0800});
    end
    // Flags set with reporting off; zero writes keep them.
    wr(ADDR_DEVICE_CONTROL, 32'h0000_0000, 1'b0);
    pulse(4'hF, 4'h0, 4'hF);
    wr(ADDR_DEVICE_STATUS, 32'h0000_0000, 1'b0);
    rd(ADDR_DEVICE_STATUS, 32'h0000_000F, 1'b0);
    wr(ADDR_DEVICE_STATUS, 32'h0000_0001, 1'b0);
    rd(ADDR_DEVICE_STATUS, 32'h0000_000E, 1'b0);
    wr(ADDR_DEVICE_STATUS, 32'h0000_000E, 1'b0);
    // Each enable alone lets only its own class be reported.
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DEVICE_CONTROL, 32'h0000_0001 << i, 1'b0);
      pulse(4'hF, 4'h1 << i, 4'hF);
      wr(ADDR_DEVICE_STATUS, 32'h0000_000F, 1'b0);
    end
    pulse(4'h8, 4'h8, 4'h8);
    rd(ADDR_DEVICE_STATUS, 32'h0000_0008, 1'b0);
    // Sequential tags wrap after 31, or after 255 with extended tags.
    wr(ADDR_DEVICE_CONTROL, 32'h0000_0000, 1'b0);
    wr(ADDR_DEBUG_CONFIG, 32'h0000_0009, 1'b0);
    takes(31, 8'h1F);
    takes(1, 8'h00);
    wr(ADDR_DEVICE_CONTROL, 32'h0000_0100, 1'b0);
    takes(255, 8'hFF);
    takes(1, 8'h00);
    wr(ADDR_DEBUG_CONFIG, 32'h0000_0008, 1'b0);
    takes(3, 8'h00);
    conclude();
  end

endmodule : test_pcie_device_control_status
